// ==== hdl/tcm_top.sv ====
// Transmit control mode bits, deferral and late collision timing with an APB register slave.
`timescale 1ns/100ps
`default_nettype none

module tcm_top
    import tcm_pkg::*;
#(
    parameter int DEFER_LIMIT = tcm_pkg::DEFER_CYCLES,
    parameter int SLOT_LIMIT = tcm_pkg::SLOT_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic [tcm_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Descriptor fetch and transmit sequencing from the MAC.
    input wire logic desc_cfg_valid,
    input wire logic [15:0] descriptor_config_word,
    input wire logic tx_commence,
    input wire logic tx_sfd_sent,
    input wire logic tx_end,
    input wire logic deferring,
    input wire logic collision,
    // Mode outputs to the MAC.
    output logic late_collision_window_start,
    output logic checksum_append_inhibit,
    output logic deferral_timer_disable,
    output logic transmit_abort,
    output logic late_collision_seen,
    // Interrupt.
    output logic irq
);
    import tcm_pkg::*;

    // ------------------------------------------------------------------
    // Reset synchroniser.
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    // Release is synchronised so no flop sees reset leave near an edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // State declarations.
    // ------------------------------------------------------------------
    logic [15:0] txctl_reg;
    logic [15:0] cfg_pending_reg;
    logic cfg_pending_valid_reg;
    logic excess_defer_reg;
    logic late_coll_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_event;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic defer_reached_d_reg;
    logic transmit_abort_reg;
    logic late_coll_pulse_reg;
    tcm_phase_type phase_reg;

    logic bus_setup;
    logic bus_write;
    logic addr_hit;
    logic desc_irq_event;
    logic defer_expired;
    logic defer_disable_eff;
    logic window_open;
    logic late_coll_event;

    tcm_count_if defer_cnt ();
    tcm_count_if slot_cnt ();

    // ------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------
    // Read data is captured in the setup cycle so every access finishes in one access cycle.
    assign bus_setup = psel && !penable;
    assign bus_write = psel && penable && pwrite && !pslverr_reg;
    assign addr_hit = (paddr == TXCTL_OFFSET) || (paddr == IRQ_STATUS_OFFSET) || (paddr == IRQ_MASK_OFFSET);
    assign pready = 1'b1;
    assign pslverr = psel && penable && pslverr_reg;
    assign prdata = prdata_reg;

    // Unmapped addresses are flagged ahead of the access phase.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_reg <= 1'b0;
        end else if (bus_setup) begin
            pslverr_reg <= !addr_hit;
        end
    end

    // Read mux; the reserved control bit and unused upper bits read as zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h00000000;
        end else if (bus_setup && !pwrite) begin
            case (paddr)
                TXCTL_OFFSET: begin
                    prdata_reg <= {16'h0000, txctl_reg[15:12], 1'b0, excess_defer_reg, 4'h0,
                                   late_coll_reg, 5'h00};
                end
                IRQ_STATUS_OFFSET: begin
                    prdata_reg <= {29'h00000000, irq_status_reg};
                end
                IRQ_MASK_OFFSET: begin
                    prdata_reg <= {29'h00000000, irq_mask_reg};
                end
                default: begin
                    prdata_reg <= 32'h00000000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Descriptor configuration and control register.
    // ------------------------------------------------------------------
    // The fetched configuration waits here until the frame actually starts.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_pending_reg <= TXCTL_RESET;
            cfg_pending_valid_reg <= 1'b0;
        end else if (desc_cfg_valid) begin
            cfg_pending_reg <= descriptor_config_word & CFG_LOAD_MASK;
            cfg_pending_valid_reg <= 1'b1;
        end else if (tx_commence) begin
            cfg_pending_valid_reg <= 1'b0;
        end
    end

    // Hardware loading at frame start wins over a simultaneous software write.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txctl_reg <= TXCTL_RESET;
        end else if (tx_commence && cfg_pending_valid_reg) begin
            txctl_reg <= cfg_pending_reg & CFG_LOAD_MASK;
        end else if (bus_write && (paddr == TXCTL_OFFSET) && pstrb[1]) begin
            txctl_reg <= {pwdata[15:12], 12'h000} & CFG_LOAD_MASK;
        end
    end

    // An interrupt fires only on a request bit that the control register does not already hold.
    assign desc_irq_event = desc_cfg_valid && descriptor_config_word[BIT_IRQ_REQ]
                            && !txctl_reg[BIT_IRQ_REQ];

    // Mode bits driven straight from the control register to the datapath.
    assign late_collision_window_start = txctl_reg[BIT_WIN_START];
    assign checksum_append_inhibit = txctl_reg[BIT_CRC_INHIBIT];
    assign deferral_timer_disable = txctl_reg[BIT_DEFER_DISABLE];

    // ------------------------------------------------------------------
    // Transmission phase tracking.
    // ------------------------------------------------------------------
    // A frame begins with its first preamble bit and opens fully after the SFD.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= TCM_IDLE;
        end else begin
            case (phase_reg)
                TCM_IDLE: begin
                    if (tx_commence) begin
                        phase_reg <= TCM_PREAMBLE;
                    end
                end
                TCM_PREAMBLE: begin
                    if (tx_end) begin
                        phase_reg <= TCM_IDLE;
                    end else if (tx_sfd_sent) begin
                        phase_reg <= TCM_FRAME;
                    end
                end
                TCM_FRAME: begin
                    if (tx_end) begin
                        phase_reg <= TCM_IDLE;
                    end
                end
                default: begin
                    phase_reg <= TCM_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Excessive deferral timer.
    // ------------------------------------------------------------------
    // The pending descriptor governs deferral, since deferral precedes its frame start.
    assign defer_disable_eff = cfg_pending_valid_reg ? cfg_pending_reg[BIT_DEFER_DISABLE]
                                                     : txctl_reg[BIT_DEFER_DISABLE];
    assign defer_cnt.run = deferring && !defer_disable_eff;
    assign defer_cnt.clear = !deferring || tx_commence;

    tcm_interval_counter #(
        .CNT_W(CNT_W),
        .LIMIT(CNT_W'(DEFER_LIMIT))
    ) u_defer_counter (
        .clk(clk),
        .rst_n(rst_n),
        .cnt(defer_cnt)
    );

    // Edge of the elapsed level; a disabled timer never reaches its limit anew.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            defer_reached_d_reg <= 1'b0;
        end else begin
            defer_reached_d_reg <= defer_cnt.reached;
        end
    end

    assign defer_expired = defer_cnt.reached && !defer_reached_d_reg && !defer_disable_eff;

    // Set beats the clear at frame start, so an expiry in that cycle is kept.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            excess_defer_reg <= 1'b0;
        end else if (defer_expired) begin
            excess_defer_reg <= 1'b1;
        end else if (tx_commence) begin
            excess_defer_reg <= 1'b0;
        end
    end

    // Abort is a one-cycle request to the transmit sequencer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_abort_reg <= 1'b0;
        end else begin
            transmit_abort_reg <= defer_expired;
        end
    end

    assign transmit_abort = transmit_abort_reg;

    // ------------------------------------------------------------------
    // Late collision window.
    // ------------------------------------------------------------------
    // The slot counter starts at the preamble or after the SFD as selected.
    assign window_open = (phase_reg == TCM_FRAME)
                         || ((phase_reg == TCM_PREAMBLE) && txctl_reg[BIT_WIN_START]);
    assign slot_cnt.run = window_open;
    assign slot_cnt.clear = tx_commence || (phase_reg == TCM_IDLE);

    tcm_interval_counter #(
        .CNT_W(CNT_W),
        .LIMIT(CNT_W'(SLOT_LIMIT))
    ) u_slot_counter (
        .clk(clk),
        .rst_n(rst_n),
        .cnt(slot_cnt)
    );

    assign late_coll_event = collision && window_open && slot_cnt.reached;

    // Flag holds until the next frame; a late collision in that same cycle still sets it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            late_coll_reg <= 1'b0;
            late_coll_pulse_reg <= 1'b0;
        end else begin
            late_coll_pulse_reg <= late_coll_event;
            if (late_coll_event) begin
                late_coll_reg <= 1'b1;
            end else if (tx_commence) begin
                late_coll_reg <= 1'b0;
            end
        end
    end

    assign late_collision_seen = late_coll_pulse_reg;

    // ------------------------------------------------------------------
    // Interrupt status, mask and output.
    // ------------------------------------------------------------------
    assign irq_event[IRQ_DESC] = desc_irq_event;
    assign irq_event[IRQ_EXCESS_DEFER] = defer_expired;
    assign irq_event[IRQ_LATE_COLL] = late_coll_event;

    // Write one to clear; a new event in the clearing cycle survives.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= IRQ_STATUS_RESET;
        end else if (bus_write && (paddr == IRQ_STATUS_OFFSET) && pstrb[0]) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    // Mask bits enable the matching status bits onto the interrupt line.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (bus_write && (paddr == IRQ_MASK_OFFSET) && pstrb[0]) begin
            irq_mask_reg <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

endmodule : tcm_top

`default_nettype wire

// ==== pkg/tcm_pkg.sv ====
// Constants, register layout and timing counts for the transmit control mode block.
package tcm_pkg;

    // ------------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] TXCTL_OFFSET = 12'h000;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h004;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h008;

    // ------------------------------------------------------------------
    // Transmit control register fields.
    // ------------------------------------------------------------------
    localparam int TXCTL_W = 16;
    localparam int BIT_IRQ_REQ = 15;
    localparam int BIT_WIN_START = 14;
    localparam int BIT_CRC_INHIBIT = 13;
    localparam int BIT_DEFER_DISABLE = 12;
    localparam int BIT_RESERVED = 11;
    localparam int BIT_EXCESS_DEFER = 10;
    localparam int BIT_LATE_COLL = 5;
    localparam logic [15:0] TXCTL_RESET = 16'h0000;
    localparam logic [15:0] CFG_LOAD_MASK = 16'hF000;

    // ------------------------------------------------------------------
    // Interrupt status and mask fields.
    // ------------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_DESC = 0;
    localparam int IRQ_EXCESS_DEFER = 1;
    localparam int IRQ_LATE_COLL = 2;
    localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam real CLK_PERIOD_NS = 5.0;
    localparam real DEFER_TIME_MS = 3.2;
    localparam real SLOT_TIME_US = 51.2;
    localparam int CNT_W = 24;
    localparam int DEFER_CYCLES = int'($ceil(DEFER_TIME_MS * 1000000.0 / CLK_PERIOD_NS));
    localparam int SLOT_CYCLES = int'($ceil(SLOT_TIME_US * 1000.0 / CLK_PERIOD_NS));

    // Transmission phase as seen by this block.
    typedef enum logic [1:0] {
        TCM_IDLE,
        TCM_PREAMBLE,
        TCM_FRAME
    } tcm_phase_type;

endpackage : tcm_pkg

// ==== pkg/tcm_count_if.sv ====
// Handshake between the control logic and one saturating interval counter.
`timescale 1ns/100ps
`default_nettype none

interface tcm_count_if;
    logic run;
    logic clear;
    logic reached;

    modport owner (output run, output clear, input reached);
    modport counter (input run, input clear, output reached);
endinterface : tcm_count_if

`default_nettype wire

// ==== hdl/tcm_interval_counter.sv ====
// Saturating interval counter that reports when a programmed cycle count has elapsed.
`timescale 1ns/100ps
`default_nettype none

module tcm_interval_counter #(
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] LIMIT = 24'h000010
) (
    // Clock and synchronised reset.
    input wire logic clk,
    input wire logic rst_n,
    // Control from the owner.
    tcm_count_if.counter cnt
);

    logic [CNT_W-1:0] count_reg;

    // Counts while running; holds at the limit so the result stays a clean level.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (cnt.clear) begin
            count_reg <= '0;
        end else if (cnt.run && (count_reg != LIMIT)) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // The interval has elapsed once the count sits at the limit.
    assign cnt.reached = (count_reg == LIMIT);

endmodule : tcm_interval_counter

`default_nettype wire

// ==== verification/tcm_mac_model.sv ====
// Behavioural model of the MAC sequencer and medium that feed the block.
`timescale 1ns/100ps
`default_nettype none

module tcm_mac_model (
    // Clock.
    input wire logic clk,
    // Sequencing towards the block.
    output logic desc_cfg_valid,
    output logic [15:0] descriptor_config_word,
    output logic tx_commence,
    output logic tx_sfd_sent,
    output logic tx_end,
    output logic deferring,
    output logic collision
);
    // Idle levels at time zero.
    initial begin
        {desc_cfg_valid, tx_commence, tx_sfd_sent, tx_end, deferring, collision} = 6'h00;
        descriptor_config_word = 16'h5A5A;
    end

    // One descriptor fetch; request words alternate in normal traffic.
    task automatic fetch(input logic [15:0] w);
        @(posedge clk);
        desc_cfg_valid <= 1'b1;
        descriptor_config_word <= w;
        @(posedge clk);
        desc_cfg_valid <= 1'b0;
        descriptor_config_word <= ~w; // Stale data must not look valid.
    endtask : fetch

    // One frame: preamble start, SFD, optional collision, end.
    task automatic frame(input int sfd_at, input int coll_at, input int len);
        for (int i = 0; i <= len; i++) begin
            @(posedge clk);
            tx_commence <= (i == 0);
            tx_sfd_sent <= (i == sfd_at);
            collision <= (i == coll_at);
            tx_end <= (i == len);
        end
        @(posedge clk);
        {tx_commence, tx_sfd_sent, collision, tx_end} <= 4'h0;
    endtask : frame

    // Medium busy for n cycles.
    task automatic defer(input int n);
        @(posedge clk);
        deferring <= 1'b1;
        repeat (n) @(posedge clk);
        deferring <= 1'b0;
    endtask : defer
endmodule : tcm_mac_model

`default_nettype wire

// ==== verification/tcm_top_chk.sv ====
// Concurrent checks on the transmit control mode block ports.
`timescale 1ns/100ps
`default_nettype none

module tcm_top_chk
    import tcm_pkg::*;
#(
    parameter int DEFER_LIMIT = 20,
    parameter int SLOT_LIMIT = 10
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // APB.
    input wire logic [tcm_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    // MAC side.
    input wire logic desc_cfg_valid,
    input wire logic [15:0] descriptor_config_word,
    input wire logic tx_commence,
    input wire logic deferring,
    input wire logic collision,
    // Outputs.
    input wire logic late_collision_window_start,
    input wire logic checksum_append_inhibit,
    input wire logic deferral_timer_disable,
    input wire logic transmit_abort,
    input wire logic late_collision_seen,
    input wire logic irq
);
    logic [15:0] pend_w;
    logic pend_v;
    logic [23:0] run_cnt;
    logic [15:0] since_cnt;
    wire [2:0] mode = {late_collision_window_start, checksum_append_inhibit, deferral_timer_disable};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // Helper state.
    // ----------------------------------------------------------------
    // Pending descriptor, consumed by the next frame start.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_v <= 1'b0;
            pend_w <= 16'h0000;
        end else if (tx_commence) begin
            pend_v <= 1'b0;
        end else if (desc_cfg_valid) begin
            pend_v <= 1'b1;
            pend_w <= descriptor_config_word;
        end
    end

    // Saturating counts so long runs never wrap into a false pass.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_cnt <= 24'h000000;
            since_cnt <= 16'h0000;
        end else begin
            run_cnt <= !deferring ? 24'h000000 : run_cnt + (run_cnt != 24'hFFFFFF);
            since_cnt <= tx_commence ? 16'h0000 : since_cnt + (since_cnt != 16'hFFFF);
        end
    end

    // ----------------------------------------------------------------
    // Properties.
    // ----------------------------------------------------------------
    sequence s_ctl_read;
        psel && penable && !pwrite && paddr == TXCTL_OFFSET;
    endsequence
    sequence s_load;
        tx_commence && pend_v;
    endsequence

    property p_mode_load;
        s_load |=> mode == pend_w[14:12];
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode bits not loaded");
    property p_mode_hold;
        !tx_commence && !(psel && penable && pwrite) |=> $stable(mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode bits moved");
    property p_abort_run;
        transmit_abort |-> run_cnt >= DEFER_LIMIT;
    endproperty
    a_abort_run: assert property (p_abort_run) else $error("abort too early");
    property p_abort_enabled;
        transmit_abort |-> !$past(pend_v ? pend_w[BIT_DEFER_DISABLE] : deferral_timer_disable);
    endproperty
    a_abort_enabled: assert property (p_abort_enabled) else $error("abort while off");
    property p_late_coll;
        late_collision_seen |-> $past(collision);
    endproperty
    a_late_coll: assert property (p_late_coll) else $error("late flag without collision");
    property p_late_window;
        late_collision_seen |-> since_cnt >= SLOT_LIMIT;
    endproperty
    a_late_window: assert property (p_late_window) else $error("late flag inside window");
    property p_reserved;
        s_ctl_read |-> prdata[11] == 1'b0 && prdata[31:16] == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit read high");
    property p_irq_fall;
        $fell(irq) |-> $past(psel && penable && pwrite);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt lost");
endmodule : tcm_top_chk

bind tcm_top tcm_top_chk #(.DEFER_LIMIT(DEFER_LIMIT), .SLOT_LIMIT(SLOT_LIMIT)) chk_u (
    .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .desc_cfg_valid(desc_cfg_valid), .descriptor_config_word(descriptor_config_word),
    .tx_commence(tx_commence), .deferring(deferring), .collision(collision),
    .late_collision_window_start(late_collision_window_start), .checksum_append_inhibit(checksum_append_inhibit),
    .deferral_timer_disable(deferral_timer_disable), .transmit_abort(transmit_abort),
    .late_collision_seen(late_collision_seen), .irq(irq));

`default_nettype wire

// ==== verification/transmit_control_mode_bits_tb.sv ====
// Self-checking testbench for the transmit control mode block.
`timescale 1ns/100ps
`default_nettype none

module transmit_control_mode_bits_tb;
    import tcm_pkg::*;
    localparam int DL = 20;
    localparam int SL = 10;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic lws, cai, dtd, abort, late;
    wire logic dv, com, sfd, tend, dfr, col;
    wire logic [15:0] dw;
    int fail_count = 0;
    int compares = 0;
    int late_cnt = 0;
    int abort_cnt = 0;

    tcm_top #(.DEFER_LIMIT(DL), .SLOT_LIMIT(SL)) dut_u (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .desc_cfg_valid(dv), .descriptor_config_word(dw), .tx_commence(com), .tx_sfd_sent(sfd),
        .tx_end(tend), .deferring(dfr), .collision(col), .late_collision_window_start(lws),
        .checksum_append_inhibit(cai), .deferral_timer_disable(dtd), .transmit_abort(abort),
        .late_collision_seen(late), .irq(irq));
    tcm_mac_model mac_u (.clk(clk), .desc_cfg_valid(dv), .descriptor_config_word(dw), .tx_commence(com),
        .tx_sfd_sent(sfd), .tx_end(tend), .deferring(dfr), .collision(col));

    // ----------------------------------------------------------------
    // Clock, pulse counters and watchdog.
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        late_cnt <= late_cnt + (late === 1'b1);
        abort_cnt <= abort_cnt + (abort === 1'b1);
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One APB transfer; it waits on pready as long as it takes, only the watchdog ends a hang.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask : wr
    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(name, exp, rd);
    endtask : rdchk

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] rd;
        logic e;
        rdchk("control", TXCTL_OFFSET, 32'h0);
        rdchk("mask", IRQ_MASK_OFFSET, 32'h0);
        apb(1'b0, 12'h00C, 32'h0, rd, e);
        chk("unmapped error", 32'h1, {31'h0, e});
    endtask : t_regs
    task automatic t_irq();
        wr(IRQ_MASK_OFFSET, 32'h0);
        mac_u.fetch(16'h8000);
        @(posedge clk);
        chk("masked irq", 32'h0, {31'h0, irq});
        rdchk("status", IRQ_STATUS_OFFSET, 32'h1);
        wr(IRQ_MASK_OFFSET, 32'h7);
        @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(IRQ_STATUS_OFFSET, 32'h1);
        @(posedge clk);
        chk("cleared irq", 32'h0, {31'h0, irq});
        mac_u.frame(4, -1, 6);
        rdchk("control", TXCTL_OFFSET, 32'h8000);
        mac_u.fetch(16'h8000);
        rdchk("repeat status", IRQ_STATUS_OFFSET, 32'h0);
        mac_u.frame(4, -1, 6);
        mac_u.fetch(16'h0000);
        mac_u.frame(4, -1, 6);
        mac_u.fetch(16'h8000);
        rdchk("rearmed status", IRQ_STATUS_OFFSET, 32'h1);
        mac_u.frame(4, -1, 6);
        wr(IRQ_STATUS_OFFSET, 32'h1);
    endtask : t_irq
    task automatic t_modes();
        logic [15:0] w[5] = '{16'h4000, 16'h2000, 16'h1000, 16'h7000, 16'h0000};
        foreach (w[i]) begin
            mac_u.fetch(w[i]);
            mac_u.frame(4, -1, 6);
            chk("mode", {29'h0, w[i][14:12]}, {29'h0, lws, cai, dtd});
        end
        wr(TXCTL_OFFSET, 32'h27FF);
        rdchk("control write", TXCTL_OFFSET, 32'h2000);
    endtask : t_modes
    task automatic t_late();
        int c[4][4] = '{'{16'h4000, 4, SL + 2, 1}, '{16'h4000, 4, SL - 2, 0}, '{0, 4, SL + 2, 0}, '{0, 4, SL + 6, 1}};
        int n;
        foreach (c[i]) begin
            n = late_cnt;
            mac_u.fetch(c[i][0][15:0]);
            mac_u.frame(c[i][1], c[i][2], 20);
            chk("late count", n + c[i][3], late_cnt);
        end
        rdchk("late control", TXCTL_OFFSET, 32'h0020);
        rdchk("late status", IRQ_STATUS_OFFSET, 32'h4);
    endtask : t_late
    task automatic t_defer();
        int n;
        n = abort_cnt;
        wr(IRQ_STATUS_OFFSET, 32'h7);
        mac_u.defer(DL - 3);
        repeat (4) @(posedge clk);
        chk("early abort", n, abort_cnt);
        mac_u.defer(DL + 6);
        chk("abort", n + 1, abort_cnt);
        rdchk("deferral control", TXCTL_OFFSET, 32'h0420);
        rdchk("deferral status", IRQ_STATUS_OFFSET, 32'h2);
        mac_u.fetch(16'h0000);
        mac_u.frame(4, -1, 6);
        rdchk("restart control", TXCTL_OFFSET, 32'h0);
        wr(TXCTL_OFFSET, 32'h1000);
        wr(IRQ_STATUS_OFFSET, 32'h7);
        mac_u.defer(DL + 6);
        chk("disabled abort", n + 1, abort_cnt);
        rdchk("disabled control", TXCTL_OFFSET, 32'h1000);
        rdchk("disabled status", IRQ_STATUS_OFFSET, 32'h0);
    endtask : t_defer

    // Main sequence; the block sees only fetches that precede frame starts.
    initial begin
        {rst_b, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_irq();
        t_modes();
        t_late();
        t_defer();
        print_verdict();
    end
endmodule : transmit_control_mode_bits_tb

`default_nettype wire
